//--- bench/ubaf_far_node.sv
// Purpose: Far node on the shared line, reduced to finished receive frames
// Assumes: One frame report per call, a one-cycle pulse
// Notes:   Released lines show inverted levels
`timescale 1ns/10ps
`default_nettype none

module ubaf_far_node (
    input  wire logic       aclk,          // System clock
    output var  logic       rx_frame_done, // Frame pulse
    output var  logic [7:0] rx_byte,       // Eight data bits
    output var  logic       rx_bit9,       // Ninth bit
    output var  logic       rx_stop_bit    // Stop bit level
);
    initial
        {rx_frame_done, rx_byte, rx_bit9, rx_stop_bit} = 11'h000;

    // One frame, then released lines
    task automatic send(input logic [7:0] b, input logic b9, input logic st);
        @(posedge aclk);
        rx_frame_done <= 1'h1;
        rx_byte <= b;
        rx_bit9 <= b9;
        rx_stop_bit <= st;
        @(posedge aclk);
        rx_frame_done <= 1'h0;
        rx_byte <= ~b;
        rx_bit9 <= ~b9;
        rx_stop_bit <= ~st;
    endtask
endmodule // ubaf_far_node

`default_nettype wire

//--- bench/ubaf_props.sv
// Purpose: Port-level checks for ubaf_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Port-level checks only
`timescale 1ns/10ps
`default_nettype none

module ubaf_props (
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Reset, active low
    input wire logic        s_axi_awvalid, // AW valid
    input wire logic        s_axi_awready, // AW ready
    input wire logic        s_axi_wvalid,  // W valid
    input wire logic        s_axi_wready,  // W ready
    input wire logic        s_axi_bvalid,  // B valid
    input wire logic        s_axi_bready,  // B ready
    input wire logic        s_axi_arvalid, // AR valid
    input wire logic        s_axi_arready, // AR ready
    input wire logic        s_axi_rvalid,  // R valid
    input wire logic        s_axi_rready,  // R ready
    input wire logic [31:0] s_axi_rdata,   // Read data
    input wire logic [1:0]  s_axi_rresp,   // Read response
    input wire logic        rx_frame_done, // Frame finished
    input wire logic [1:0]  serial_mode,   // Mode bits
    input wire logic        rx_accept      // Frame accepted
);
    // All checks share the one clock and its reset
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data did not follow the address");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data stayed after it was taken");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stayed after it was taken");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while response pending");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("new read taken while data pending");
    a_read_fill: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
        && (s_axi_rresp == 2'h0 || s_axi_rdata == 32'h0)) else $error("read data upper bits wrong");
    a_accept_cause: assert property (rx_accept |-> $past(rx_frame_done))
        else $error("accept without a frame");
    a_mode0_accept: assert property (rx_frame_done && serial_mode == 2'h0 |=> rx_accept)
        else $error("mode 0 frame filtered");
endmodule // ubaf_props

bind ubaf_top ubaf_props u_ubaf_props (.*);

`default_nettype wire

//--- bench/ubaf_top_bench.sv
// Purpose: Self-checking bench for ubaf_top
// Assumes: AXI4-Lite master tasks, far node model feeds frames
// Notes:   Generator period is measured at the transmit clock
`timescale 1ns/10ps
`default_nettype none
`include "ubaf_consts.vh"

module ubaf_top_bench;
    localparam [11:0] RL = {`UBAF_IDX_RELOAD, 2'h0}, GC = {`UBAF_IDX_GEN_CTRL, 2'h0}, SA = {`UBAF_IDX_SLV_ADDR, 2'h0},
        SM = {`UBAF_IDX_SLV_MASK, 2'h0}, SC = {`UBAF_IDX_SER_CTRL, 2'h0}, PC = {`UBAF_IDX_PWR_CTRL, 2'h0},
        IS = {`UBAF_IDX_IRQ_STAT, 2'h0}, IM = {`UBAF_IDX_IRQ_MASK, 2'h0};
    localparam [11:0] REGS [8] = '{RL, GC, SA, SM, SC, PC, IS, IM};
    logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        t1_overflow = 1'h0, t2_overflow = 1'h0, zero_mode_default_tick = 1'h0;
    logic        timer2_tx_clock_select = 1'h0, timer2_rx_clock_select = 1'h0;
    logic [1:0]  r;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_frame_done;
    wire logic   rx_bit9, rx_stop_bit, tx_bit_clock, rx_bit_clock, zero_mode_tick, baud_double, rx_accept, irq;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp, serial_mode;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0]  rx_byte;
    int          mismatches = 0, num_checks = 0, n;

    // 40 MHz system clock
    always #12.5 aclk = ~aclk;

    ubaf_top u_ubaf_top (.*);
    ubaf_far_node u_ubaf_far_node (.*);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic aw_ok = 1'h0, w_ok = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("register %h", a), e, d);
    endtask

    // Pulse {t1, t2, mode 0}, expect {tx, rx, mode 0}
    task automatic src(input logic [7:0] gc, input logic [1:0] sel, input logic [2:0] p, input logic [2:0] e);
        wr(GC, gc);
        {timer2_tx_clock_select, timer2_rx_clock_select} <= sel;
        @(posedge aclk);
        {t1_overflow, t2_overflow, zero_mode_default_tick} <= p;
        @(posedge aclk);
        {t1_overflow, t2_overflow, zero_mode_default_tick} <= 3'h0;
        #1;
        chk("tx rx mode0 clocks", e, {tx_bit_clock, rx_bit_clock, zero_mode_tick});
    endtask

    // Filter case: control value, frame, expected accept
    task automatic fr(input logic [7:0] sc, input logic [7:0] b, input logic b9, input logic st, input logic e);
        wr(SC, sc);
        u_ubaf_far_node.send(b, b9, st);
        #1;
        chk("rx_accept", e, rx_accept);
    endtask

    // Cycles between two transmit ticks
    task automatic gap(output int k);
        k = 0;
        do @(posedge aclk); while (!tx_bit_clock);
        do
        begin
            @(posedge aclk);
            k++;
        end
        while (!tx_bit_clock);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Twenty thousand cycles means a hang
    initial
    begin
        #(25 * 20000);
        mismatches++;
        conclude();
    end

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 8; i++) rdc(REGS[i], 32'h0);
        rd(12'h000);
        chk("unmapped rresp", `UBAF_RESP_SLVERR, r);
        wr(12'h000, 32'h5A);
        chk("unmapped bresp", `UBAF_RESP_SLVERR, r);
        src(8'h00, 2'h0, 3'h4, 3'h6);
        src(8'h00, 2'h2, 3'h2, 3'h4);
        src(8'h00, 2'h2, 3'h4, 3'h2);
        src(8'h0C, 2'h3, 3'h2, 3'h0);
        src(8'h08, 2'h1, 3'h2, 3'h2);
        src(8'h00, 2'h0, 3'h1, 3'h1);
        src(8'h01, 2'h0, 3'h1, 3'h0);
        rdc(GC, 32'h01);
        // Missing stop bit recorded while bit 7 shows the mode bit, then seen once bit 7 shows framing error
        wr(SC, 32'h40);
        u_ubaf_far_node.send(8'h55, 1'h0, 1'h0);
        rdc(SC, 32'h41);
        rdc(IS, 32'h3);
        wr(PC, 32'hC0);
        #1;
        chk("baud_double", 1'h1, baud_double);
        rdc(SC, 32'hC1);
        u_ubaf_far_node.send(8'h55, 1'h0, 1'h1);
        rdc(SC, 32'hC1);
        wr(SC, 32'h40);
        rdc(SC, 32'h40);
        wr(SC, 32'hC0);
        #1;
        chk("serial_mode", 2'h1, serial_mode);
        wr(SC, 32'h40);
        wr(PC, 32'h00);
        // Interrupt raised, cleared, then masked out
        wr(IS, 32'h7);
        wr(IM, 32'h1);
        u_ubaf_far_node.send(8'h33, 1'h0, 1'h1);
        @(posedge aclk) #1;
        chk("irq raised", 1'h1, irq);
        wr(IS, 32'h1);
        #1;
        chk("irq cleared", 1'h0, irq);
        wr(IM, 32'h0);
        u_ubaf_far_node.send(8'h33, 1'h0, 1'h1);
        @(posedge aclk) #1;
        chk("irq masked", 1'h0, irq);
        rdc(IS, 32'h1);
        // Given C0 with mask FD, broadcast FD
        wr(SA, 32'hC0);
        wr(SM, 32'hFD);
        fr(8'hE0, 8'hC2, 1'h1, 1'h1, 1'h1);
        fr(8'hE0, 8'hC1, 1'h1, 1'h1, 1'h0);
        fr(8'hE0, 8'hFF, 1'h1, 1'h1, 1'h1);
        fr(8'hE0, 8'hC0, 1'h0, 1'h1, 1'h0);
        fr(8'h60, 8'hC0, 1'h0, 1'h1, 1'h1);
        fr(8'h60, 8'hC0, 1'h0, 1'h0, 1'h0);
        fr(8'h20, 8'h11, 1'h0, 1'h0, 1'h1);
        fr(8'hC0, 8'h11, 1'h0, 1'h1, 1'h1);
        // Generator periods with reload FC, then halted
        wr(IS, 32'h7);
        wr(RL, 32'hFC);
        wr(GC, 32'h1A);
        gap(n);
        chk("fast period", 32'd4, n);
        wr(GC, 32'h18);
        gap(n);
        gap(n);
        chk("slow period", 32'd24, n);
        wr(GC, 32'h08);
        repeat (2) @(posedge aclk);
        n = 0;
        repeat (60) @(posedge aclk) n += tx_bit_clock;
        chk("halted ticks", 32'd0, n);
        rdc(IS, 32'h4);
        conclude();
    end
endmodule // ubaf_top_bench

`default_nettype wire

//--- design/ubaf_addr_match.v
// Purpose: Given and broadcast slave address comparison
// Assumes: Purely combinational
// Notes:   All-zero address and mask match everything
`timescale 1ns/10ps
`default_nettype none

module ubaf_addr_match #(
    parameter WIDTH = 8
) (
    input  wire [WIDTH-1:0] rx_byte,    // Received byte
    input  wire [WIDTH-1:0] slv_addr,   // slave_address
    input  wire [WIDTH-1:0] slv_mask,   // slave_address_mask
    output wire             hit         // Given or broadcast match
);

    wire [WIDTH-1:0] bcast;
    wire             given_hit;
    wire             bcast_hit;

    // masked compare for the given address
    assign given_hit = ~|((rx_byte ^ slv_addr) & slv_mask);
    // ones of the OR must match
    assign bcast     = slv_addr | slv_mask;
    assign bcast_hit = ((rx_byte & bcast) == bcast);
    assign hit       = given_hit | bcast_hit;

endmodule // ubaf_addr_match
`default_nettype wire

//--- design/ubaf_baud_gen.v
// Purpose: Internal 8-bit reload baud counter with slow or fast input
// Assumes: Single clock, synchronous active-low reset
// Notes:   Tick is a one-cycle pulse on each overflow
`timescale 1ns/10ps
`default_nettype none
`include "ubaf_consts.vh"

module ubaf_baud_gen #(
    parameter WIDTH = 8
) (
    input  wire             aclk,      // System clock
    input  wire             aresetn,   // Synchronous reset, active low
    input  wire             run,       // Count enable
    input  wire             fast,      // 1 undivided clock, 0 divided by six
    input  wire [WIDTH-1:0] reload,    // Reload value on overflow
    output reg  [WIDTH-1:0] count_q,   // Current counter value
    output reg              tick_q     // Overflow pulse
);

    reg  [2:0] pre_q;
    wire       step;

    // Prescaler step; cleared while halted so restart is clean
    assign step = run & (fast | (pre_q == `UBAF_SLOW_LAST));

    always @(posedge aclk)
    begin
        if (!aresetn)
            pre_q <= 3'h0;
        else if (!run || fast || pre_q == `UBAF_SLOW_LAST)
            pre_q <= 3'h0;
        else
            pre_q <= pre_q + 3'h1;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_q <= {WIDTH{1'b0}};
            tick_q  <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (step)
            begin
                if (&count_q)
                begin
                    count_q <= reload;
                    tick_q  <= 1'b1;
                end
                else
                    count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // ubaf_baud_gen
`default_nettype wire

//--- design/ubaf_consts.vh
// Purpose: Shared constants for the baud select and address filter block
// Assumes: Word registers on AXI4-Lite, register index times four is the byte address
// Notes:   Definitions only, guarded against double inclusion
`ifndef UBAF_CONSTS_VH
`define UBAF_CONSTS_VH

// Register indices
`define UBAF_IDX_RELOAD      10'h09A
`define UBAF_IDX_GEN_CTRL    10'h09B
`define UBAF_IDX_SLV_ADDR    10'h0A9
`define UBAF_IDX_SLV_MASK    10'h0B9
`define UBAF_IDX_SER_CTRL    10'h0C0
`define UBAF_IDX_PWR_CTRL    10'h0C1
`define UBAF_IDX_IRQ_STAT    10'h0C2
`define UBAF_IDX_IRQ_MASK    10'h0C3

// Fields of baud_gen_control
`define UBAF_GC_RUN          4
`define UBAF_GC_TX_GEN       3
`define UBAF_GC_RX_GEN       2
`define UBAF_GC_SPEED        1
`define UBAF_GC_ZERO_GEN     0

// Fields of serial_control
`define UBAF_SC_MODE_HI      7
`define UBAF_SC_MODE_LO      6
`define UBAF_SC_MPE          5
`define UBAF_SC_RI           0

// Fields of power_control
`define UBAF_PC_DOUBLE       7
`define UBAF_PC_FE_VIEW      6

// Interrupt status bits
`define UBAF_IRQ_RX          0
`define UBAF_IRQ_FE          1
`define UBAF_IRQ_GEN         2
`define UBAF_IRQ_W           3

// Reset values
`define UBAF_RST_BYTE        8'h00
`define UBAF_RST_IRQ         3'h0

// Slow mode steps every sixth clock
`define UBAF_SLOW_LAST       3'h5

// Bus responses
`define UBAF_RESP_OKAY       2'h0
`define UBAF_RESP_SLVERR     2'h2

`endif

//--- design/ubaf_top.v
// Purpose: Baud source selection, framing error flag and address filter with AXI4-Lite registers
// Assumes: Receive engine pulses once per finished frame
// Notes:   Shift engines and timers live outside; this block only steers and filters
`timescale 1ns/10ps
`default_nettype none
`include "ubaf_consts.vh"

// Notes on behaviour
// - Internal baud counter runs only while the run bit is one.
// - Transmit clock comes from the timers when bit 3 is zero, else generator.
// - Receive clock comes from the timers when bit 2 is zero, else generator.
// - Speed bit selects system clock over six, or undivided system clock.
// - Zero-mode source bit routes generator overflow to the shift mode clock.
// - A missing stop bit in a received frame sets framing error in modes 1, 2 and 3.
// - Serial control bit 7 is framing error when view select is one, else mode bit.
// - Hardware never clears framing error; only a software write of zero with view select one does.
// - Framing errors are recorded even while the view select bit is zero.
// - Filtering acts only with multiprocessor enable set in modes 1, 2 and 3.
// - Nine-bit modes with filtering set receive flag only on address match.
// - In modes 2 and 3 only frames with ninth bit one count as address candidates.
// - Mode 1 with filtering needs a valid stop bit and an address match.
// - Mode 0 ignores filtering whatever multiprocessor enable says.
// - Given address compares received bits where the mask is one.
// - Broadcast address is address OR mask; its ones must match.
module ubaf_top #(
    parameter AW = 12
) (
    input  wire          aclk,             // System clock, 40 MHz
    input  wire          aresetn,          // Synchronous reset, active low
    input  wire [AW-1:0] s_axi_awaddr,     // Write address
    input  wire          s_axi_awvalid,    // Write address valid
    output reg           s_axi_awready,    // Write address ready
    input  wire [31:0]   s_axi_wdata,      // Write data
    input  wire [3:0]    s_axi_wstrb,      // Write strobes
    input  wire          s_axi_wvalid,     // Write data valid
    output reg           s_axi_wready,     // Write data ready
    output reg  [1:0]    s_axi_bresp,      // Write response
    output reg           s_axi_bvalid,     // Write response valid
    input  wire          s_axi_bready,     // Write response ready
    input  wire [AW-1:0] s_axi_araddr,     // Read address
    input  wire          s_axi_arvalid,    // Read address valid
    output reg           s_axi_arready,    // Read address ready
    output reg  [31:0]   s_axi_rdata,      // Read data
    output reg  [1:0]    s_axi_rresp,      // Read response
    output reg           s_axi_rvalid,     // Read data valid
    input  wire          s_axi_rready,     // Read data ready
    input  wire          t1_overflow,      // Timer 1 overflow pulse
    input  wire          t2_overflow,      // Timer 2 overflow pulse
    input  wire          timer2_tx_clock_select, // Timer 2 drives transmit
    input  wire          timer2_rx_clock_select, // Timer 2 drives receive
    input  wire          zero_mode_default_tick, // Default mode 0 shift tick
    input  wire          rx_frame_done,    // Receive frame finished, pulse
    input  wire [7:0]    rx_byte,          // Received eight data bits
    input  wire          rx_bit9,          // Ninth bit in modes 2 and 3
    input  wire          rx_stop_bit,      // Sampled stop bit level
    output reg           tx_bit_clock,     // Transmit baud tick
    output reg           rx_bit_clock,     // Receive baud tick
    output reg           zero_mode_tick,   // Mode 0 shift tick
    output reg  [1:0]    serial_mode,      // Mode bits high and low
    output reg           baud_double,      // baud_double_select level
    output reg           rx_accept,        // Frame accepted pulse
    output reg           irq               // Level interrupt
);

    // Register state
    reg  [7:0] reload_q;
    reg  [4:0] gen_ctrl_q;
    reg  [7:0] slv_addr_q;
    reg  [7:0] slv_mask_q;
    reg        mode_hi_q;
    reg        mode_lo_q;
    reg        mpe_q;
    reg        ri_q;
    reg        fe_q;
    reg        dbl_q;
    reg        fe_view_q;
    reg  [`UBAF_IRQ_W-1:0] stat_q;
    reg  [`UBAF_IRQ_W-1:0] mask_q;

    // Write channel holding
    reg          aw_held_q;
    reg [AW-1:0] aw_addr_q;
    reg          w_held_q;
    reg  [31:0]  w_data_q;
    reg  [3:0]   w_strb_q;

    wire       gen_tick;
    wire       addr_hit;
    wire       do_write;
    wire       wr_lane;
    wire [9:0] wr_idx;
    wire [9:0] rd_idx;
    reg        wr_ok;
    reg [31:0] rd_word;
    reg        rd_ok;

    // Frame evaluation
    reg        fe_event;
    reg        ri_event;
    wire [1:0] mode;

    assign mode     = {mode_hi_q, mode_lo_q};
    assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_lane  = w_strb_q[0];
    assign wr_idx   = aw_addr_q[11:2];
    assign rd_idx   = s_axi_araddr[11:2];

    ubaf_baud_gen #(
        .WIDTH   (8)
    ) u_gen (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (gen_ctrl_q[`UBAF_GC_RUN]),
        .fast    (gen_ctrl_q[`UBAF_GC_SPEED]),
        .reload  (reload_q),
        .count_q (),
        .tick_q  (gen_tick)
    );

    ubaf_addr_match #(
        .WIDTH    (8)
    ) u_match (
        .rx_byte  (rx_byte),
        .slv_addr (slv_addr_q),
        .slv_mask (slv_mask_q),
        .hit      (addr_hit)
    );

    // Decide flag updates for a finished frame
    always @*
    begin
        fe_event = 1'b0;
        ri_event = 1'b0;
        if (rx_frame_done)
        begin
            fe_event = (mode != 2'h0) & ~rx_stop_bit;
            case (mode)
                2'h0: ri_event = 1'b1;
                2'h1: ri_event = mpe_q ? (rx_stop_bit & addr_hit) : 1'b1;
                2'h2: ri_event = mpe_q ? (rx_bit9 & addr_hit) : 1'b1;
                2'h3: ri_event = mpe_q ? (rx_bit9 & addr_hit) : 1'b1;
                default: ri_event = 1'b0;
            endcase
        end
    end

    // Write address decode
    always @*
    begin
        case (wr_idx)
            `UBAF_IDX_RELOAD,
            `UBAF_IDX_GEN_CTRL,
            `UBAF_IDX_SLV_ADDR,
            `UBAF_IDX_SLV_MASK,
            `UBAF_IDX_SER_CTRL,
            `UBAF_IDX_PWR_CTRL,
            `UBAF_IDX_IRQ_STAT,
            `UBAF_IDX_IRQ_MASK: wr_ok = 1'b1;
            default:            wr_ok = 1'b0;
        endcase
    end

    // Read decode; reserved bits read as zero
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_idx)
            `UBAF_IDX_RELOAD:   rd_word[7:0] = reload_q;
            `UBAF_IDX_GEN_CTRL: rd_word[4:0] = gen_ctrl_q;
            `UBAF_IDX_SLV_ADDR: rd_word[7:0] = slv_addr_q;
            `UBAF_IDX_SLV_MASK: rd_word[7:0] = slv_mask_q;
            // bit 7 view depends on select
            `UBAF_IDX_SER_CTRL: rd_word[7:0] = {(fe_view_q ? fe_q : mode_hi_q), mode_lo_q, mpe_q, 4'h0, ri_q};
            `UBAF_IDX_PWR_CTRL: rd_word[7:0] = {dbl_q, fe_view_q, 6'h00};
            `UBAF_IDX_IRQ_STAT: rd_word[`UBAF_IRQ_W-1:0] = stat_q;
            `UBAF_IDX_IRQ_MASK: rd_word[`UBAF_IRQ_W-1:0] = mask_q;
            default:            rd_ok = 1'b0;
        endcase
    end

    // Write channel: address and data taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            aw_addr_q     <= {AW{1'b0}};
            w_held_q      <= 1'b0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `UBAF_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `UBAF_RESP_OKAY : `UBAF_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: one-cycle answer, one read in flight
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `UBAF_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `UBAF_RESP_OKAY : `UBAF_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    // Plain configuration registers; only the low byte lane is stored
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reload_q   <= `UBAF_RST_BYTE;
            gen_ctrl_q <= 5'h00;
            slv_addr_q <= `UBAF_RST_BYTE;
            slv_mask_q <= `UBAF_RST_BYTE;
            mode_lo_q  <= 1'b0;
            mpe_q      <= 1'b0;
            dbl_q      <= 1'b0;
            fe_view_q  <= 1'b0;
            mask_q     <= `UBAF_RST_IRQ;
        end
        else if (do_write && wr_lane)
        begin
            case (wr_idx)
                `UBAF_IDX_RELOAD:   reload_q   <= w_data_q[7:0];
                `UBAF_IDX_GEN_CTRL: gen_ctrl_q <= w_data_q[4:0];
                `UBAF_IDX_SLV_ADDR: slv_addr_q <= w_data_q[7:0];
                `UBAF_IDX_SLV_MASK: slv_mask_q <= w_data_q[7:0];
                `UBAF_IDX_SER_CTRL:
                begin
                    mode_lo_q <= w_data_q[`UBAF_SC_MODE_LO];
                    mpe_q     <= w_data_q[`UBAF_SC_MPE];
                end
                `UBAF_IDX_PWR_CTRL:
                begin
                    dbl_q     <= w_data_q[`UBAF_PC_DOUBLE];
                    fe_view_q <= w_data_q[`UBAF_PC_FE_VIEW];
                end
                `UBAF_IDX_IRQ_MASK: mask_q <= w_data_q[`UBAF_IRQ_W-1:0];
                default:            mask_q <= mask_q;
            endcase
        end
    end

    // Bit 7, framing error and receive flag; hardware set wins over a write
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_hi_q <= 1'b0;
            fe_q      <= 1'b0;
            ri_q      <= 1'b0;
        end
        else
        begin
            if (do_write && wr_lane && wr_idx == `UBAF_IDX_SER_CTRL)
            begin
                if (fe_view_q)
                    fe_q <= w_data_q[`UBAF_SC_MODE_HI] | fe_event;
                else
                    mode_hi_q <= w_data_q[`UBAF_SC_MODE_HI];
                ri_q <= w_data_q[`UBAF_SC_RI] | ri_event;
            end
            else
            begin
                fe_q <= fe_q | fe_event;
                ri_q <= ri_q | ri_event;
            end
            if (do_write && wr_lane && wr_idx == `UBAF_IDX_SER_CTRL && !fe_view_q)
                fe_q <= fe_q | fe_event;
        end
    end

    // Sticky interrupt status, write one to clear, new events win
    always @(posedge aclk)
    begin
        if (!aresetn)
            stat_q <= `UBAF_RST_IRQ;
        else if (do_write && wr_lane && wr_idx == `UBAF_IDX_IRQ_STAT)
            stat_q <= (stat_q & ~w_data_q[`UBAF_IRQ_W-1:0]) | {gen_tick, fe_event, ri_event};
        else
            stat_q <= stat_q | {gen_tick, fe_event, ri_event};
    end

    // Clock steering and registered outputs; one cycle later than the source tick
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_bit_clock   <= 1'b0;
            rx_bit_clock   <= 1'b0;
            zero_mode_tick <= 1'b0;
            serial_mode    <= 2'h0;
            baud_double    <= 1'b0;
            rx_accept      <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            tx_bit_clock   <= gen_ctrl_q[`UBAF_GC_TX_GEN] ? gen_tick :
                              (timer2_tx_clock_select ? t2_overflow : t1_overflow);
            rx_bit_clock   <= gen_ctrl_q[`UBAF_GC_RX_GEN] ? gen_tick :
                              (timer2_rx_clock_select ? t2_overflow : t1_overflow);
            zero_mode_tick <= gen_ctrl_q[`UBAF_GC_ZERO_GEN] ? gen_tick : zero_mode_default_tick;
            serial_mode    <= mode;
            baud_double    <= dbl_q;
            rx_accept      <= ri_event;
            irq            <= |(stat_q & mask_q);
        end
    end

endmodule // ubaf_top
`default_nettype wire
